// ===== core/mft_timer_cfg.svh
// register offsets, reset values and field constants of the multifunction timer
`ifndef MFT_TIMER_CFG_SVH
`define MFT_TIMER_CFG_SVH

// byte register offsets in the special-purpose register space
`define MFT_ADDR_W 3
`define MFT_OFS_CNT_LO 3'h0
`define MFT_OFS_CNT_HI 3'h1
`define MFT_OFS_CAP1_LO 3'h2
`define MFT_OFS_CAP1_HI 3'h3
`define MFT_OFS_CMP1_LO 3'h4
`define MFT_OFS_CMP1_HI 3'h5
`define MFT_OFS_PER_LO 3'h6
`define MFT_OFS_PER_HI 3'h7

// widths and reset values
`define MFT_CNT_W 16
`define MFT_BYTE_RST 8'h00
`define MFT_WORD_RST 16'h0000
`define MFT_WORD_ONE 16'h0001
`define MFT_WORD_MAX 16'hFFFF
`define MFT_RST_SYNC_RST 2'h0

`endif

// ===== core/mft_pkg.sv
// types shared by the multifunction timer
package mft_pkg;
  typedef logic [7:0] mft_byte_t;
  typedef logic [15:0] mft_word_t;
  // capture edge select; both upper codes mean any edge
  typedef enum logic [1:0] {
    MFT_EDGE_FALL = 2'h0,
    MFT_EDGE_RISE = 2'h1,
    MFT_EDGE_ANY = 2'h2,
    MFT_EDGE_ANY2 = 2'h3
  } mft_edge_t;
endpackage

// ===== core/mft_timer.sv
// one 16-bit multifunction timer channel: pwm, timer and capture/compare
`timescale 1ns/1ps
`include "mft_timer_cfg.svh"

// limitations: no prescaler and no external clock, so the counter steps on
// every clk while counterEnable is high; configuration arrives as plain levels
// and the sticky interrupt flags live outside, fed by the event pulses below.
// compare values above the period in pwm mode give no defined waveform.
module mft_timer #(
  parameter int CNT_W = `MFT_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  // special-purpose register port, one byte per access
  input wire logic [`MFT_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire mft_pkg::mft_byte_t regWdata,
  output mft_pkg::mft_byte_t regRdata,
  // configuration levels held outside this block
  input wire logic captureMode,
  input wire logic counterEnable,
  input wire logic outputPinEnable,
  input wire logic firstCaptureEnable,
  input wire logic secondCaptureEnable,
  input wire logic resetOnFirstCapture,
  input wire logic captureInputTie,
  input wire mft_pkg::mft_edge_t firstCaptureEdgeSelect,
  input wire mft_pkg::mft_edge_t secondCaptureEdgeSelect,
  // one-cycle command strobes
  input wire logic forceOutputHigh,
  input wire logic forceOutputLow,
  input wire logic timerClearBit,
  // capture pins
  input wire logic firstCaptureInput,
  input wire logic secondCaptureInput,
  // timer output pin and its driver enable
  output logic timerOutputPin,
  output logic timerOutputEnable,
  // one-cycle event pulses toward the flag register
  output logic overflowFlag,
  output logic firstCompareEvent,
  output logic secondCompareEvent,
  output logic firstCaptureEvent,
  output logic secondCaptureEvent
);
  import mft_pkg::*;

  // the byte-split register map only serves a 16-bit counter
  if (CNT_W != 16) begin : g_width_check
    $error("mft_timer supports CNT_W = 16 only");
  end

  // edge detector shared by both capture inputs
  function automatic logic edgeHit(
    input logic prev,
    input logic cur,
    input mft_edge_t sel
  );
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (sel)
      MFT_EDGE_FALL: edgeHit = fall;
      MFT_EDGE_RISE: edgeHit = rise;
      default: edgeHit = rise || fall;
    endcase
  endfunction

  logic [1:0] rstSync;
  logic rstn;

  // reset released through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= `MFT_RST_SYNC_RST;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // counter and live compare values
  mft_word_t counter;
  mft_word_t cmp1Int;
  mft_word_t cmp2Int;

  // pwm copies, swapped in only at cycle end
  mft_word_t act1;
  mft_word_t act2;

  // capture results as the register reads see them
  mft_word_t cap1;
  mft_word_t cap2;

  // bytes as written, read back whether committed or not
  mft_byte_t cmp1Lo;
  mft_byte_t cmp1Hi;
  mft_byte_t cmp2Lo;
  mft_byte_t cmp2Hi;

  // high halves frozen by the matching low-byte read
  mft_byte_t cntHiLatch;
  mft_byte_t cap1HiLatch;
  mft_byte_t cap2HiLatch;

  // output level ahead of the pin flop
  logic outLevel;

  // per-channel capture view: index 0 first input, index 1 second
  logic capPin [2];
  logic capEnable [2];
  logic capPrev [2];
  logic capHit [2];
  mft_edge_t capSel [2];
  mft_word_t capValue [2];

  // decoded events of the current cycle
  logic commit1;
  logic commit2;
  logic cap1Hit;
  logic cap2Hit;
  logic pwmWrap;
  logic pwmFall;
  logic ccMatch;
  logic counterReset;
  logic wrapOver;

  // next-state values
  mft_word_t next_cmp1Int;
  mft_word_t next_cmp2Int;
  mft_word_t next_counter;

  // compare commits happen on the high-byte write only
  always_comb begin
    commit1 = regWrite && (regAddr == `MFT_OFS_CMP1_HI);
    commit2 = regWrite && (regAddr == `MFT_OFS_PER_HI) && !captureMode;
    next_cmp1Int = commit1 ? {regWdata, cmp1Lo} : cmp1Int;
    next_cmp2Int = commit2 ? {regWdata, cmp2Lo} : cmp2Int;
  end

  // capture sources per channel; inputs are already synchronous to clk
  // the tie bit steers the first pin into channel two, freeing that pin
  always_comb begin
    capPin[0] = firstCaptureInput;
    capPin[1] = captureInputTie ? firstCaptureInput : secondCaptureInput;
    capEnable[0] = firstCaptureEnable;
    capEnable[1] = captureMode && secondCaptureEnable;
    capSel[0] = firstCaptureEdgeSelect;
    capSel[1] = secondCaptureEdgeSelect;
  end

  // compare decisions; pwm uses the applied copies, capture mode the live value
  always_comb begin
    pwmWrap = !captureMode && counterEnable && (counter == (act2 - `MFT_WORD_ONE));
    pwmFall = !captureMode && counterEnable && (counter == (act1 - `MFT_WORD_ONE))
      && (act1 != `MFT_WORD_RST) && (act1 != act2);
    ccMatch = captureMode && counterEnable && (counter == (cmp1Int - `MFT_WORD_ONE));
    counterReset = timerClearBit || (cap1Hit && resetOnFirstCapture);
    wrapOver = counterEnable && !counterReset && (counter == `MFT_WORD_MAX);
  end

  // next counter value, clear bit first, then capture reset, then period end
  always_comb begin
    if (counterReset) begin
      next_counter = `MFT_WORD_RST;
    end else if (pwmWrap) begin
      next_counter = `MFT_WORD_RST;
    end else if (counterEnable) begin
      next_counter = counter + `MFT_WORD_ONE;
    end else begin
      next_counter = counter;
    end
  end

  // the counter itself; software can never load it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter <= `MFT_WORD_RST;
    end else begin
      counter <= next_counter;
    end
  end

  // written compare bytes, read back as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp1Lo <= `MFT_BYTE_RST;
      cmp1Hi <= `MFT_BYTE_RST;
      cmp2Lo <= `MFT_BYTE_RST;
      cmp2Hi <= `MFT_BYTE_RST;
    end else if (regWrite) begin
      case (regAddr)
        `MFT_OFS_CMP1_LO: cmp1Lo <= regWdata;
        `MFT_OFS_CMP1_HI: cmp1Hi <= regWdata;
        // the period pair is read-only while it holds second capture
        `MFT_OFS_PER_LO: if (!captureMode) cmp2Lo <= regWdata;
        `MFT_OFS_PER_HI: if (!captureMode) cmp2Hi <= regWdata;
        default: ;
      endcase
    end
  end

  // internal compare values loaded by the high-byte write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp1Int <= `MFT_WORD_RST;
      cmp2Int <= `MFT_WORD_RST;
    end else begin
      cmp1Int <= next_cmp1Int;
      cmp2Int <= next_cmp2Int;
    end
  end

  // applied pwm values change only when a cycle ends, so no runt pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act1 <= `MFT_WORD_RST;
      act2 <= `MFT_WORD_RST;
    end else if (captureMode || pwmWrap || counterReset) begin
      act1 <= next_cmp1Int;
      act2 <= next_cmp2Int;
    end
  end

  // output level; wrap beats the fall point so equal compares stay high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outLevel <= 1'b0;
    end else if (captureMode) begin
      if (forceOutputHigh && outputPinEnable) begin
        outLevel <= 1'b1;
      end else if (forceOutputLow && outputPinEnable) begin
        outLevel <= 1'b0;
      end else if (ccMatch) begin
        outLevel <= !outLevel;
      end
    end else if (pwmWrap) begin
      outLevel <= (next_cmp1Int != `MFT_WORD_RST);
    end else if (pwmFall) begin
      outLevel <= 1'b0;
    end
  end

  // pin drive; timer mode is simply pwm with the driver off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerOutputPin <= 1'b0;
      timerOutputEnable <= 1'b0;
    end else begin
      timerOutputPin <= outLevel && outputPinEnable;
      timerOutputEnable <= outputPinEnable;
    end
  end

  // both capture channels share one edge detector and one register shape
  for (genvar ch = 0; ch < 2; ch++) begin : g_capture
    // trigger when the chosen edge shows between two samples
    assign capHit[ch] = capEnable[ch]
      && edgeHit(capPrev[ch], capPin[ch], capSel[ch]);

    // history starts low, so a pin idling high gives one rising edge after reset
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        capPrev[ch] <= 1'b0;
        capValue[ch] <= `MFT_WORD_RST;
      end else begin
        capPrev[ch] <= capPin[ch];
        // the count before any capture reset is the one kept
        if (capHit[ch]) begin
          capValue[ch] <= counter;
        end
      end
    end
  end

  // named views of the two channels for the rest of the block
  assign cap1Hit = capHit[0];
  assign cap2Hit = capHit[1];
  assign cap1 = capValue[0];
  assign cap2 = capValue[1];

  // event pulses, one cycle each
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflowFlag <= 1'b0;
      firstCompareEvent <= 1'b0;
      secondCompareEvent <= 1'b0;
      firstCaptureEvent <= 1'b0;
      secondCaptureEvent <= 1'b0;
    end else begin
      overflowFlag <= wrapOver;
      // pwm: reset to zero marks output set, also in both special cases
      firstCompareEvent <= captureMode ? ccMatch : pwmWrap;
      secondCompareEvent <= pwmFall;
      firstCaptureEvent <= cap1Hit;
      secondCaptureEvent <= cap2Hit;
    end
  end

  // high-byte latches loaded by low-byte reads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntHiLatch <= `MFT_BYTE_RST;
      cap1HiLatch <= `MFT_BYTE_RST;
      cap2HiLatch <= `MFT_BYTE_RST;
    end else if (regRead) begin
      case (regAddr)
        `MFT_OFS_CNT_LO: cntHiLatch <= counter[15:8];
        `MFT_OFS_CAP1_LO: cap1HiLatch <= cap1[15:8];
        `MFT_OFS_PER_LO: if (captureMode) cap2HiLatch <= cap2[15:8];
        default: ;
      endcase
    end
  end

  // read data, registered, valid the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= `MFT_BYTE_RST;
    end else if (regRead) begin
      case (regAddr)
        `MFT_OFS_CNT_LO: regRdata <= counter[7:0];
        `MFT_OFS_CNT_HI: regRdata <= cntHiLatch;
        `MFT_OFS_CAP1_LO: regRdata <= cap1[7:0];
        `MFT_OFS_CAP1_HI: regRdata <= cap1HiLatch;
        `MFT_OFS_CMP1_LO: regRdata <= cmp1Lo;
        `MFT_OFS_CMP1_HI: regRdata <= cmp1Hi;
        `MFT_OFS_PER_LO: regRdata <= captureMode ? cap2[7:0] : cmp2Lo;
        `MFT_OFS_PER_HI: regRdata <= captureMode ? cap2HiLatch : cmp2Hi;
        default: regRdata <= `MFT_BYTE_RST;
      endcase
    end
  end

endmodule

// ===== verification/mft_timer_props.sv
// port-level assertion checker for the multifunction timer
`timescale 1ns/1ps
`include "mft_timer_cfg.svh"
module mft_timer_props
  import mft_pkg::*;
(
  input logic clk,
  input logic resetn,
  input logic [`MFT_ADDR_W-1:0] regAddr,
  input logic regWrite,
  input logic regRead,
  input mft_pkg::mft_byte_t regWdata,
  input mft_pkg::mft_byte_t regRdata,
  input logic captureMode,
  input logic outputPinEnable,
  input logic firstCaptureEnable,
  input logic secondCaptureEnable,
  input logic captureInputTie,
  input mft_pkg::mft_edge_t firstCaptureEdgeSelect,
  input mft_pkg::mft_edge_t secondCaptureEdgeSelect,
  input logic forceOutputHigh,
  input logic forceOutputLow,
  input logic firstCaptureInput,
  input logic timerOutputPin,
  input logic timerOutputEnable,
  input logic overflowFlag,
  input logic firstCaptureEvent,
  input logic secondCaptureEvent
);
  logic [1:0] age;
  // outputs are held quiet two edges after release, so checks wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || age != 2'h3);
  property p_pin_off; !timerOutputEnable |-> !timerOutputPin; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin high while disabled");
  property p_force_hi; captureMode && outputPinEnable && forceOutputHigh ##1 outputPinEnable
    |=> timerOutputPin; endproperty
  a_force_hi: assert property (p_force_hi) else $error("force high lost");
  property p_force_lo; captureMode && outputPinEnable && forceOutputLow && !forceOutputHigh
    |=> ##1 !timerOutputPin; endproperty
  a_force_lo: assert property (p_force_lo) else $error("force low lost");
  property p_cap_edge; firstCaptureEnable && ((firstCaptureEdgeSelect == MFT_EDGE_RISE
    && $rose(firstCaptureInput)) || (firstCaptureEdgeSelect == MFT_EDGE_FALL
    && $fell(firstCaptureInput)) || (firstCaptureEdgeSelect[1] && $changed(firstCaptureInput)))
    |=> firstCaptureEvent; endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("capture edge missed");
  property p_cap_wrong; firstCaptureEnable && firstCaptureEdgeSelect == MFT_EDGE_RISE
    && $fell(firstCaptureInput) |=> !firstCaptureEvent; endproperty
  a_cap_wrong: assert property (p_cap_wrong) else $error("capture on wrong edge");
  property p_tie; captureMode && captureInputTie && secondCaptureEnable
    && secondCaptureEdgeSelect[1] && $changed(firstCaptureInput) |=> secondCaptureEvent;
  endproperty
  a_tie: assert property (p_tie) else $error("tied capture missed");
  property p_ovf_pulse; overflowFlag |=> !overflowFlag; endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
  property p_rdata_hold; !regRead |=> $stable(regRdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cmp_rb; regWrite && regAddr == `MFT_OFS_CMP1_LO ##1 regRead
    && regAddr == `MFT_OFS_CMP1_LO |=> regRdata == $past(regWdata, 2); endproperty
  a_cmp_rb: assert property (p_cmp_rb) else $error("compare readback wrong");
endmodule
bind mft_timer mft_timer_props u_props (.*);

// ===== verification/mft_pins_model.sv
// capture pin drivers and output pin observer outside the timer
`timescale 1ns/1ps
module mft_pins_model (
  input logic clk,
  input logic pin,
  output logic cap1,
  output logic cap2,
  output int hiLen,
  output int perLen
);
  int run = 0;
  int since = 0;
  logic last = 1'b0;
  initial begin
    cap1 = 1'b0;
    cap2 = 1'b0;
    hiLen = 0;
    perLen = 0;
  end
  // last complete high run and rise-to-rise distance, in clocks
  always @(posedge clk) begin
    perLen <= (pin && !last) ? since : perLen;
    since <= (pin && !last) ? 1 : since + 1;
    hiLen <= (!pin && last) ? run : hiLen;
    run <= pin ? run + 1 : 0;
    last <= pin;
  end
  // caller aligns to the falling edge; levels are held until changed
  task automatic drive(input logic c1, input logic c2);
    cap1 = c1;
    cap2 = c2;
  endtask
endmodule

// ===== verification/mft_timer_test.sv
// self-checking bench for one multifunction timer channel
`timescale 1ns/1ps
`include "mft_timer_cfg.svh"
module mft_timer_test;
  import mft_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [`MFT_ADDR_W-1:0] regAddr;
  logic regWrite, regRead, captureMode, counterEnable, outputPinEnable;
  logic firstCaptureEnable, secondCaptureEnable, resetOnFirstCapture, captureInputTie;
  logic forceOutputHigh, forceOutputLow, timerClearBit, firstCaptureInput, secondCaptureInput;
  logic timerOutputPin, timerOutputEnable, overflowFlag, firstCompareEvent;
  logic secondCompareEvent, firstCaptureEvent, secondCaptureEvent;
  mft_byte_t regWdata, regRdata, rb;
  mft_word_t rw;
  mft_edge_t firstCaptureEdgeSelect, secondCaptureEdgeSelect;
  int n_fail = 0;
  int check_count = 0;
  int hiLen, perLen, nh;
  int ev1 = 0, ev2 = 0, ovf = 0, fc = 0, sc = 0;
  time wrDrop = 0;
  time rdDrop = 0;
  mft_timer dut (.*);
  mft_pins_model pins (.clk, .pin(timerOutputPin), .cap1(firstCaptureInput),
    .cap2(secondCaptureInput), .hiLen, .perLen);
  always #5 clk = ~clk;
  // pulse counters; cleared by the sequence between windows
  always @(posedge clk) begin
    ev1 <= ev1 + int'(firstCaptureEvent === 1'b1);
    ev2 <= ev2 + int'(secondCaptureEvent === 1'b1);
    ovf <= ovf + int'(overflowFlag === 1'b1);
    fc <= fc + int'(firstCompareEvent === 1'b1);
    sc <= sc + int'(secondCompareEvent === 1'b1);
  end
  task automatic check(input string what, input mft_word_t got, input mft_word_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  // a strobe just lowered gets one idle edge before it rises again
  task automatic wr(input logic [2:0] a, input mft_byte_t d);
    if ($time == wrDrop) begin
      step(1);
    end
    regAddr = a;
    regWdata = d;
    strobe(regWrite);
    wrDrop = $time;
  endtask
  // low byte first: the high write commits the pair
  task automatic wr16(input logic [2:0] a, input mft_word_t v);
    wr(a, v[7:0]);
    wr(a + 3'h1, v[15:8]);
  endtask
  task automatic rd(input logic [2:0] a);
    if ($time == rdDrop) begin
      step(1);
    end
    regAddr = a;
    strobe(regRead);
    rdDrop = $time;
    rb = regRdata;
  endtask
  task automatic rd16(input logic [2:0] a);
    rd(a);
    rw[7:0] = rb;
    rd(a + 3'h1);
    rw[15:8] = rb;
  endtask
  task automatic highs(input int n);
    nh = 0;
    fc = 0;
    sc = 0;
    repeat (n) begin
      step(1);
      nh += int'(timerOutputPin === 1'b1);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a hang past the longest sequence is a failure
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    {regWrite, regRead, captureMode, counterEnable, outputPinEnable} = '0;
    {firstCaptureEnable, secondCaptureEnable, resetOnFirstCapture, captureInputTie} = '0;
    {forceOutputHigh, forceOutputLow, timerClearBit} = '0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    firstCaptureEdgeSelect = MFT_EDGE_RISE;
    secondCaptureEdgeSelect = MFT_EDGE_ANY;
    step(5);
    resetn = 1'b1;
    step(4);
    wr(`MFT_OFS_CNT_LO, 8'hAA);
    rd(`MFT_OFS_CNT_LO);
    check("counter ro", {8'h00, rb}, 16'h0000);
    wr16(`MFT_OFS_CMP1_LO, 16'h0003);
    wr16(`MFT_OFS_PER_LO, 16'h0005);
    rd16(`MFT_OFS_CMP1_LO);
    check("cmp1 read", rw, 16'h0003);
    wr(`MFT_OFS_CMP1_LO, 8'h7E);
    rd(`MFT_OFS_CMP1_LO);
    check("cmp1 low uncommitted", {8'h00, rb}, 16'h007E);
    rd16(`MFT_OFS_PER_LO);
    check("period read", rw, 16'h0005);
    strobe(timerClearBit);
    {counterEnable, outputPinEnable} = 2'h3;
    step(30);
    check("high time", 16'(hiLen), 16'h0003);
    check("period", 16'(perLen), 16'h0005);
    outputPinEnable = 1'b0;
    step(3);
    highs(10);
    check("timer mode pin", 16'(nh), 16'h0000);
    outputPinEnable = 1'b1;
    wr16(`MFT_OFS_CMP1_LO, 16'h0002);
    step(30);
    check("new high time", 16'(hiLen), 16'h0002);
    check("kept period", 16'(perLen), 16'h0005);
    highs(20);
    check("pwm high count", 16'(nh), 16'h0008);
    check("clear events", 16'(sc), 16'h0004);
    for (int i = 0; i < 2; i++) begin
      wr16(`MFT_OFS_CMP1_LO, (i == 0) ? 16'h0000 : 16'h0005);
      step(12);
      highs(20);
      check("duty extreme", 16'(nh), (i == 0) ? 16'd0 : 16'd20);
      check("reset events", 16'(fc), 16'h0004);
      check("no clear events", 16'(sc), 16'h0000);
    end
    captureMode = 1'b1;
    strobe(timerClearBit);
    step(16'h1FA);
    rd(`MFT_OFS_CNT_LO);
    check("low near wrap", {15'h0000, rb >= 8'hF0}, 16'h0001);
    step(8);
    rd(`MFT_OFS_CNT_HI);
    check("latched high", {8'h00, rb}, 16'h0001);
    ovf = 0;
    step(16'hFFFF);
    check("overflow", 16'(ovf), 16'h0001);
    counterEnable = 1'b0;
    strobe(timerClearBit);
    counterEnable = 1'b1;
    step(16'h34);
    counterEnable = 1'b0;
    rd16(`MFT_OFS_CNT_LO);
    check("frozen count", rw, 16'h0034);
    {firstCaptureEnable, secondCaptureEnable, captureInputTie} = 3'h7;
    for (int i = 0; i < 4; i++) begin
      firstCaptureEdgeSelect = mft_edge_t'(i);
      step(2);
      {ev1, ev2} = '0;
      pins.drive(1'b1, 1'b0);
      step(3);
      pins.drive(1'b0, 1'b1);
      step(3);
      check("edge events", 16'(ev1), (i > 1) ? 16'h0002 : 16'h0001);
      check("tied events", 16'(ev2), 16'h0002);
    end
    wr16(`MFT_OFS_CAP1_LO, 16'hBEEF);
    wr16(`MFT_OFS_PER_LO, 16'hBEEF);
    rd16(`MFT_OFS_CAP1_LO);
    check("cap1", rw, 16'h0034);
    rd16(`MFT_OFS_PER_LO);
    check("cap2", rw, 16'h0034);
    counterEnable = 1'b1;
    step(16'h10);
    {counterEnable, resetOnFirstCapture} = 2'h1;
    firstCaptureEdgeSelect = MFT_EDGE_RISE;
    step(2);
    counterEnable = 1'b1;
    pins.drive(1'b1, 1'b0);
    step(1);
    counterEnable = 1'b0;
    step(2);
    rd16(`MFT_OFS_CNT_LO);
    check("count after capture reset", rw, 16'h0000);
    rd16(`MFT_OFS_CAP1_LO);
    check("count before reset", rw, 16'h0044);
    strobe(forceOutputHigh);
    step(2);
    check("forced high", {15'h0000, timerOutputPin}, 16'h0001);
    strobe(forceOutputLow);
    step(2);
    check("forced low", {15'h0000, timerOutputPin}, 16'h0000);
    wr16(`MFT_OFS_CMP1_LO, 16'h0003);
    counterEnable = 1'b1;
    step(6);
    counterEnable = 1'b0;
    step(2);
    check("compare toggle", {15'h0000, timerOutputPin}, 16'h0001);
    complete_run();
  end
endmodule
